// [hdl/srw_map.vh]
`ifndef SRW_MAP_VH
`define SRW_MAP_VH
`define SRW_CLK_MHZ 125
`define SRW_RST_PULSE_MS 200
`define SRW_RST_MIN_MS 140
`define SRW_WDOG_TIMEOUT_MS 1600
`define SRW_KICK_MIN_NS 50
`define SRW_RST_CYCLES (`SRW_RST_PULSE_MS * 1000 * `SRW_CLK_MHZ)
`define SRW_WDOG_CYCLES (`SRW_WDOG_TIMEOUT_MS * 1000 * `SRW_CLK_MHZ)
`define SRW_KICK_CYCLES ((`SRW_KICK_MIN_NS * `SRW_CLK_MHZ + 999) / 1000)
`define SRW_CNT_W 32
`endif

// [hdl/srw_supervisor.v]
`include "srw_map.vh"
`default_nettype none
module srw_supervisor #(
  parameter [`SRW_CNT_W-1:0] RST_CYCLES = `SRW_RST_CYCLES,
  parameter [`SRW_CNT_W-1:0] WDOG_CYCLES = `SRW_WDOG_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Reset causes
  input wire supply_low,
  input wire manual_reset_n,
  // Watchdog
  input wire watchdog_kick,
  input wire watchdog_disable,
  output wire watchdog_expired_n,
  // Power fail
  input wire power_fail_sense,
  output wire power_fail_warn_n,
  // Reset outputs
  output wire reset_out_n,
  output wire reset_out
);

  // Reset stretcher states, one-hot
  localparam [2:0] ST_HOLD = 3'h1;
  localparam [2:0] ST_COUNT = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  // Watchdog states, one-hot
  localparam [2:0] WD_OFF = 3'h1;
  localparam [2:0] WD_RUN = 3'h2;
  localparam [2:0] WD_FIRE = 3'h4;

  // Counter constants
  localparam [`SRW_CNT_W-1:0] CNT_ZERO = {`SRW_CNT_W{1'b0}};
  localparam [`SRW_CNT_W-1:0] CNT_ONE = {{(`SRW_CNT_W-1){1'b0}}, 1'b1};
  localparam [`SRW_CNT_W-1:0] RST_LAST = RST_CYCLES - CNT_ONE;
  localparam [`SRW_CNT_W-1:0] WDOG_LAST = WDOG_CYCLES - CNT_ONE;

  // Reset stretcher
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`SRW_CNT_W-1:0] rst_cnt_reg;
  reg [`SRW_CNT_W-1:0] rst_cnt_next;
  reg rst_n_reg;
  reg rst_n_next;
  reg rst_hi_reg;
  reg rst_hi_next;

  // Watchdog
  reg [2:0] wd_state_reg;
  reg [2:0] wd_state_next;
  reg [`SRW_CNT_W-1:0] wd_cnt_reg;
  reg [`SRW_CNT_W-1:0] wd_cnt_next;
  reg wd_exp_reg;
  reg wd_exp_next;
  reg kick_q_reg;
  reg kick_q_next;

  // Power fail
  reg pf_reg;
  reg pf_next;

  // Decoded conditions
  wire cause_mr;
  wire cause_supply;
  wire cause;
  wire rst_done;
  wire kick_edge;
  wire wd_done;
  wire wdo_force;

  assign cause_mr = ~manual_reset_n;
  assign cause_supply = supply_low;
  // Expiry is left out on purpose: it resets only when wired back
  assign cause = cause_mr | cause_supply;
  assign rst_done = (rst_cnt_reg >= RST_LAST);
  assign kick_edge = watchdog_kick ^ kick_q_reg;
  assign wd_done = (wd_cnt_reg >= WDOG_LAST);
  assign wdo_force = supply_low;

  // Reset stretcher, next state
  always @* begin
    state_next = state_reg;
    rst_cnt_next = rst_cnt_reg;
    rst_n_next = rst_n_reg;
    case (state_reg)
      ST_HOLD: begin
        if (cause) begin
          state_next = ST_HOLD;
          rst_cnt_next = CNT_ZERO;
          rst_n_next = 1'b0;
        end else if (rst_done) begin
          state_next = ST_RUN;
          rst_cnt_next = CNT_ZERO;
          rst_n_next = 1'b1;
        end else begin
          state_next = ST_COUNT;
          rst_cnt_next = rst_cnt_reg + CNT_ONE;
          rst_n_next = 1'b0;
        end
      end

      ST_COUNT: begin
        if (cause) begin
          state_next = ST_HOLD;
          rst_cnt_next = CNT_ZERO;
          rst_n_next = 1'b0;
        end else if (rst_done) begin
          state_next = ST_RUN;
          rst_cnt_next = CNT_ZERO;
          rst_n_next = 1'b1;
        end else begin
          state_next = ST_COUNT;
          rst_cnt_next = rst_cnt_reg + CNT_ONE;
          rst_n_next = 1'b0;
        end
      end

      ST_RUN: begin
        if (cause) begin
          state_next = ST_HOLD;
          rst_cnt_next = CNT_ZERO;
          rst_n_next = 1'b0;
        end else begin
          state_next = ST_RUN;
          rst_cnt_next = CNT_ZERO;
          rst_n_next = 1'b1;
        end
      end

      default: begin
        state_next = ST_HOLD;
        rst_cnt_next = CNT_ZERO;
        rst_n_next = 1'b0;
      end
    endcase
  end

  // Active-high reset, next value
  always @* begin
    rst_hi_next = ~rst_n_next;
  end

  // Stretcher state register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stretch counter
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_reg <= CNT_ZERO;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // Active-low reset register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_n_reg <= 1'b0;
    end else begin
      rst_n_reg <= rst_n_next;
    end
  end

  // Active-high reset register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_hi_reg <= 1'b1;
    end else begin
      rst_hi_reg <= rst_hi_next;
    end
  end

  // Kick level, next value
  always @* begin
    kick_q_next = watchdog_kick;
  end

  // Watchdog, next state
  always @* begin
    wd_state_next = wd_state_reg;
    wd_cnt_next = wd_cnt_reg;
    wd_exp_next = wd_exp_reg;
    // A floating kick input arrives here as the disable flag
    if (watchdog_disable) begin
      wd_state_next = WD_OFF;
      wd_cnt_next = CNT_ZERO;
      wd_exp_next = 1'b0;
    end else if (kick_edge) begin
      wd_state_next = WD_RUN;
      wd_cnt_next = CNT_ZERO;
      wd_exp_next = 1'b0;
    end else begin
      case (wd_state_reg)
        WD_OFF: begin
          if (wd_done) begin
            wd_state_next = WD_FIRE;
            wd_cnt_next = wd_cnt_reg;
            wd_exp_next = 1'b1;
          end else begin
            wd_state_next = WD_RUN;
            wd_cnt_next = wd_cnt_reg + CNT_ONE;
            wd_exp_next = 1'b0;
          end
        end

        WD_RUN: begin
          if (wd_done) begin
            wd_state_next = WD_FIRE;
            wd_cnt_next = wd_cnt_reg;
            wd_exp_next = 1'b1;
          end else begin
            wd_state_next = WD_RUN;
            wd_cnt_next = wd_cnt_reg + CNT_ONE;
            wd_exp_next = 1'b0;
          end
        end

        WD_FIRE: begin
          wd_state_next = WD_FIRE;
          wd_cnt_next = wd_cnt_reg;
          wd_exp_next = 1'b1;
        end

        default: begin
          wd_state_next = WD_OFF;
          wd_cnt_next = CNT_ZERO;
          wd_exp_next = 1'b0;
        end
      endcase
    end
  end

  // Watchdog state register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_state_reg <= WD_OFF;
    end else begin
      wd_state_reg <= wd_state_next;
    end
  end

  // Watchdog counter
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_cnt_reg <= CNT_ZERO;
    end else begin
      wd_cnt_reg <= wd_cnt_next;
    end
  end

  // Expiry flag
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_exp_reg <= 1'b0;
    end else begin
      wd_exp_reg <= wd_exp_next;
    end
  end

  // Previous kick level for edge detection
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kick_q_reg <= 1'b0;
    end else begin
      kick_q_reg <= kick_q_next;
    end
  end

  // Power fail, next value
  always @* begin
    pf_next = power_fail_sense;
  end

  // Power fail register, apart from every other path
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf_reg <= 1'b0;
    end else begin
      pf_reg <= pf_next;
    end
  end

  // Watchdog output, forced low at once by a low supply
  assign watchdog_expired_n = ~(wd_exp_reg | wdo_force);

  // Power fail output
  assign power_fail_warn_n = pf_reg;

  // Reset outputs
  assign reset_out_n = rst_n_reg;
  assign reset_out = rst_hi_reg;
endmodule
`default_nettype wire

// [tb/srw_asserts.sv]
`default_nettype none
module srw_asserts #(
  parameter RST_CYCLES = 20,
  parameter WDOG_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Reset causes
  input wire logic supply_low,
  input wire logic manual_reset_n,
  // Watchdog
  input wire logic watchdog_kick,
  input wire logic watchdog_disable,
  input wire logic watchdog_expired_n,
  // Power fail
  input wire logic power_fail_sense,
  input wire logic power_fail_warn_n,
  // Reset outputs
  input wire logic reset_out_n,
  input wire logic reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire c = supply_low | !manual_reset_n;
  logic [31:0] n;
  logic [31:0] k;
  logic kd;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Cycles since a cause was seen, and since the last kick edge
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      n <= 32'h0000_0000;
      k <= 32'h0000_0000;
      kd <= 1'b0;
    end else begin
      n <= c ? 32'h0000_0000 : n + 32'h0000_0001;
      k <= (watchdog_disable || kd != watchdog_kick) ? 32'h0000_0000 : k + 32'h0000_0001;
      kd <= watchdog_kick;
    end
  end
  rst_cause_a: assert property (c |=> !reset_out_n) else $error("no reset");
  rst_min_a: assert property ($rose(reset_out_n) |-> n >= RST_CYCLES)
    else $error("short reset");
  rst_max_a: assert property (n > RST_CYCLES + 2 |-> reset_out_n)
    else $error("long reset");
  rst_pair_a: assert property (reset_out != reset_out_n) else $error("pair");
  low_wdo_a: assert property (supply_low |-> !watchdog_expired_n) else $error("wdo");
  pf_copy_a: assert property (!$past(sys_rst) |-> power_fail_warn_n == $past(power_fail_sense))
    else $error("pfo");
  wd_fire_a: assert property (k > WDOG_CYCLES + 2 |-> !watchdog_expired_n)
    else $error("no expiry");
  wd_hold_a: assert property (k > 1 && k < WDOG_CYCLES - 2 && !supply_low |-> watchdog_expired_n)
    else $error("early expiry");
  cover property ($rose(reset_out_n));
  cover property ($fell(watchdog_expired_n) && !supply_low);
  cover property ($fell(power_fail_warn_n));
endmodule
bind srw_supervisor srw_asserts #(.RST_CYCLES(RST_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) chk (.*);
`default_nettype wire

// [tb/srw_cpu.sv]
`default_nettype none
module srw_cpu (
  // Clock and control
  input wire logic clk,
  input wire logic stall,
  // Kick toward the supervisor
  output logic watchdog_kick
);
  timeunit 1ns; timeprecision 1ps;
  initial watchdog_kick = 0;
  // Each level held 7 cycles, 56 ns, just over the 50 ns minimum
  always begin
    repeat (7) @(posedge clk);
    #1 if (!stall) watchdog_kick = !watchdog_kick;
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns; timeprecision 1ps;
  localparam int RC = 20, WC = 50;
  logic clk = 0, sys_rst = 1, supply_low = 0, manual_reset_n = 1, watchdog_disable = 0;
  logic power_fail_sense = 1, stall = 0;
  wire watchdog_kick, watchdog_expired_n, power_fail_warn_n, reset_out_n, reset_out;
  int miscompares = 0, n_tests = 0, cyc = 0;
  logic [31:0] r;
  always #4 clk = !clk;
  always @(posedge clk) if (++cyc > 2000) begin miscompares++; end_sim; end
  srw_supervisor #(.RST_CYCLES(RC), .WDOG_CYCLES(WC)) uut (.*);
  srw_cpu cpu (.*);
  task chk(string s, logic e, logic g);
    n_tests++;
    if (g !== e) begin miscompares++; $display("ERROR %s exp %b got %b", s, e, g); end
  endtask
  function automatic logic exp_wdo(logic low);
    return !low;
  endfunction
  task tick(int m); repeat (m) @(posedge clk); #1; endtask
  task end_sim;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    r = $urandom(7958);
    tick(4); sys_rst = 0;
    tick(RC + 3); chk("rst_n", 1, reset_out_n);
    chk("rst", 0, reset_out);
    repeat (6) begin
      r = $urandom;
      power_fail_sense = r[0]; supply_low = r[1]; manual_reset_n = r[1];
      tick(1 + r[3:2]); chk("rst_n", 0, reset_out_n);
      chk("wdo", exp_wdo(r[1]), watchdog_expired_n);
      chk("pfo", r[0], power_fail_warn_n);
      supply_low = 0; manual_reset_n = 1;
      tick(RC - 2); chk("rst_n", 0, reset_out_n);
      tick(5); chk("rst_n", 1, reset_out_n);
    end
    // Supply recovers first; the stretch waits for the manual input
    supply_low = 1; manual_reset_n = 0; tick(3);
    supply_low = 0; tick(RC + 3); chk("rst_n", 0, reset_out_n);
    manual_reset_n = 1; tick(RC - 2); chk("rst_n", 0, reset_out_n);
    tick(5); chk("rst_n", 1, reset_out_n);
    stall = 1; tick(WC + 9); chk("wdo", 0, watchdog_expired_n);
    chk("rst_n", 1, reset_out_n);
    stall = 0; tick(9); chk("wdo", 1, watchdog_expired_n);
    stall = 1; watchdog_disable = 1; tick(WC + 9);
    chk("wdo", 1, watchdog_expired_n);
    end_sim;
  end
endmodule
`default_nettype wire
